/* File: src/dsam_pkg.sv */
package dsam_pkg;

    // ------------------------------------------------------------
    // instruction fields
    // ------------------------------------------------------------
    localparam int MAJOR_LSB = 26;
    localparam int RT_LSB    = 21;
    localparam int RS_LSB    = 16;
    localparam int ACC_LSB   = 14;
    localparam int RD_LSB    = 11;
    localparam int MINOR_LSB = 6;

    localparam logic [5:0]  MAJOR_POOL       = 6'h00;
    localparam logic [5:0]  EXT_POOL         = 6'h3c;
    localparam logic [4:0]  ZERO_FIELD       = 5'h00;
    localparam logic [7:0]  MINOR_SHIFT_IN   = 8'h09;
    localparam logic [7:0]  MINOR_WR_LOW     = 8'hc1;
    localparam logic [10:0] MINOR_PH_MUL     = 11'h02d;
    localparam logic [10:0] MINOR_PH_MUL_SAT = 11'h42d;

    // ------------------------------------------------------------
    // control register and datapath
    // ------------------------------------------------------------
    localparam int          POS_LSB    = 0;
    localparam int          POS_W      = 6;
    localparam logic [5:0]  POS_STEP   = 6'h20;
    localparam int          OUFLAG_BIT = 21;
    localparam logic [31:0] CTL_RESET  = 32'h0000_0000;
    localparam logic [63:0] ACC_RESET  = 64'h0;
    localparam int          HALF_W     = 32;
    localparam int          LANE_W     = 16;

    localparam logic signed [31:0] LANE_MAX = 32'sh0000_7fff;
    localparam logic signed [31:0] LANE_MIN = 32'shffff_8000;
    localparam logic [15:0]        SAT_MAX  = 16'h7fff;
    localparam logic [15:0]        SAT_MIN  = 16'h8000;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_SHIFT_IN,
        OP_WR_LOW,
        OP_PH_MUL,
        OP_PH_MUL_SAT
    } dsam_op_t;

endpackage

/* File: src/dsam_datapath.sv */
`timescale 1ns/1ns
// How it works
// - shift-in decoded: pools 000000/111100, minor 00001001, 25:21 zero
// - shift-in moves old accumulator low half into its upper half
// - shift-in loads accumulator low half from the source register
// - shift-in adds 32 to the six-bit position field of control
// - two-bit selector picks one of four accumulators, zero is legacy pair
// - shift-in never raises a data-dependent exception
// - low write decoded: pools 000000/111100, minor 11000001, 25:21 zero
// - low-half write copies source into low half, upper half kept
// - paired multiply decoded by minor 00000101101, saturating 10000101101
// - each signed halfword lane multiplied into a 32-bit product
// - plain variant writes low 16 bits of each lane product
// - saturating variant clamps lanes to 7fff or 8000
// - saturating variant sets control bit 21 on any lane overflow
// - multiplies leave accumulators one to three unchanged
// - multiply raises reserved-instruction or dsp-disabled exception
// - upper half is bits 63:32, lower half bits 31:0
module dsam_datapath #(
    parameter int NUM_ACC = 4
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RST_N,
    input  wire logic        I_VALID,
    input  wire logic [31:0] I_INSTR,
    input  wire logic [31:0] I_RS_DATA,
    input  wire logic [31:0] I_RT_DATA,
    input  wire logic        I_DSP_EN,
    input  wire logic        I_DSP_R2_EN,
    input  wire logic        I_CTL_WE,
    input  wire logic [31:0] I_CTL_WDATA,
    input  wire logic [1:0]  I_ACC_RD_SEL,
    output logic             O_WB_VALID,
    output logic             O_WB_RD_WE,
    output logic [4:0]       O_WB_RD_ADDR,
    output logic [31:0]      O_WB_RD_DATA,
    output logic             O_EXC_RI,
    output logic             O_EXC_DSP_DIS,
    output logic [31:0]      O_DSP_CONTROL,
    output logic [63:0]      O_ACC_RD_DATA
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    // the selector field is two bits wide, so exactly four fit
    if (NUM_ACC != 4) begin : g_bad_num_acc
        $error("NUM_ACC must be 4");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_ACC-1:0][63:0] acc;
        logic [31:0]              ctl;
        logic                     wb_valid;
        logic                     rd_we;
        logic [4:0]               rd_addr;
        logic [31:0]              rd_data;
        logic                     exc_ri;
        logic                     exc_dis;
        logic [63:0]              acc_rd;
    } dsam_state_t;

    dsam_state_t s_q;
    dsam_state_t s_d;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    dsam_pkg::dsam_op_t op;
    logic [1:0]         sel;
    logic [4:0]         rd_field;
    logic               axf_form;
    logic               is_mul;
    logic               need_dsp;
    logic               take_ri;
    logic               take_dis;
    logic               go;

    assign sel      = I_INSTR[dsam_pkg::ACC_LSB +: 2];
    assign rd_field = I_INSTR[dsam_pkg::RD_LSB +: 5];
    assign axf_form =
        (I_INSTR[dsam_pkg::MAJOR_LSB +: 6] == dsam_pkg::MAJOR_POOL) &&
        (I_INSTR[5:0] == dsam_pkg::EXT_POOL) &&
        (I_INSTR[dsam_pkg::RT_LSB +: 5] == dsam_pkg::ZERO_FIELD);

    always_comb begin
        op = dsam_pkg::OP_NONE;
        if (axf_form &&
            I_INSTR[dsam_pkg::MINOR_LSB +: 8] ==
            dsam_pkg::MINOR_SHIFT_IN) begin
            op = dsam_pkg::OP_SHIFT_IN;
        end else if (axf_form &&
            I_INSTR[dsam_pkg::MINOR_LSB +: 8] ==
            dsam_pkg::MINOR_WR_LOW) begin
            op = dsam_pkg::OP_WR_LOW;
        end else if (I_INSTR[dsam_pkg::MAJOR_LSB +: 6] ==
            dsam_pkg::MAJOR_POOL) begin
            if (I_INSTR[10:0] == dsam_pkg::MINOR_PH_MUL) begin
                op = dsam_pkg::OP_PH_MUL;
            end else if (I_INSTR[10:0] ==
                dsam_pkg::MINOR_PH_MUL_SAT) begin
                op = dsam_pkg::OP_PH_MUL_SAT;
            end
        end
    end

    assign is_mul   = (op == dsam_pkg::OP_PH_MUL) ||
                      (op == dsam_pkg::OP_PH_MUL_SAT);
    // accumulator zero with the low-half write is a base-core move
    assign need_dsp = is_mul || (op == dsam_pkg::OP_SHIFT_IN) ||
                      ((op == dsam_pkg::OP_WR_LOW) && (sel != 2'h0));
    // only the opcode and enables feed these, never operand data
    assign take_ri  = I_VALID && is_mul && !I_DSP_R2_EN;
    assign take_dis = I_VALID && need_dsp && !I_DSP_EN &&
                      !take_ri;
    assign go       = I_VALID && (op != dsam_pkg::OP_NONE) &&
                      !take_ri && !take_dis;

    // ------------------------------------------------------------
    // paired halfword multiply
    // ------------------------------------------------------------
    logic signed [31:0] prod_hi;
    logic signed [31:0] prod_lo;
    logic [16:0]        sat_hi;
    logic [16:0]        sat_lo;
    logic [31:0]        mul_wrap;
    logic [31:0]        mul_sat;
    logic               mul_ovf;

    function automatic logic [16:0] lane_sat(
        input logic signed [31:0] p
    );
        logic [16:0] r;
        r = {1'b0, p[15:0]};
        if (p > dsam_pkg::LANE_MAX) begin
            r = {1'b1, dsam_pkg::SAT_MAX};
        end else if (p < dsam_pkg::LANE_MIN) begin
            r = {1'b1, dsam_pkg::SAT_MIN};
        end
        return r;
    endfunction

    assign prod_hi  = $signed(I_RS_DATA[31:16]) *
                      $signed(I_RT_DATA[31:16]);
    assign prod_lo  = $signed(I_RS_DATA[15:0]) *
                      $signed(I_RT_DATA[15:0]);
    assign sat_hi   = lane_sat(prod_hi);
    assign sat_lo   = lane_sat(prod_lo);
    assign mul_wrap = {prod_hi[15:0], prod_lo[15:0]};
    assign mul_sat  = {sat_hi[15:0], sat_lo[15:0]};
    assign mul_ovf  = sat_hi[16] || sat_lo[16];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d          = s_q;
        s_d.wb_valid = 1'b0;
        s_d.rd_we    = 1'b0;
        s_d.exc_ri   = take_ri;
        s_d.exc_dis  = take_dis;
        s_d.acc_rd   = s_q.acc[I_ACC_RD_SEL];
        // a control write in the same cycle is applied first, so a
        // flag the instruction sets is never lost to it
        if (I_CTL_WE) begin
            s_d.ctl = I_CTL_WDATA;
        end
        if (go) begin
            s_d.wb_valid = 1'b1;
            unique case (op)
                dsam_pkg::OP_SHIFT_IN: begin
                    s_d.acc[sel] = {s_q.acc[sel][31:0],
                                    I_RS_DATA};
                    // a position of 32 or above simply wraps
                    s_d.ctl[dsam_pkg::POS_LSB +: dsam_pkg::POS_W] =
                        s_d.ctl[dsam_pkg::POS_LSB +: dsam_pkg::POS_W] +
                        dsam_pkg::POS_STEP;
                end
                dsam_pkg::OP_WR_LOW: begin
                    s_d.acc[sel][31:0] = I_RS_DATA;
                end
                dsam_pkg::OP_PH_MUL: begin
                    // accumulators stay as they are, zero included
                    s_d.rd_we   = 1'b1;
                    s_d.rd_addr = rd_field;
                    s_d.rd_data = mul_wrap;
                end
                dsam_pkg::OP_PH_MUL_SAT: begin
                    s_d.rd_we   = 1'b1;
                    s_d.rd_addr = rd_field;
                    s_d.rd_data = mul_sat;
                    if (mul_ovf) begin
                        s_d.ctl[dsam_pkg::OUFLAG_BIT] = 1'b1;
                    end
                end
                dsam_pkg::OP_NONE: begin
                end
            endcase
        end
    end

    // one register stage: every effect lands on the same edge
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            s_q     <= '0;
            s_q.acc <= {NUM_ACC{dsam_pkg::ACC_RESET}};
            s_q.ctl <= dsam_pkg::CTL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign O_WB_VALID    = s_q.wb_valid;
    assign O_WB_RD_WE    = s_q.rd_we;
    assign O_WB_RD_ADDR  = s_q.rd_addr;
    assign O_WB_RD_DATA  = s_q.rd_data;
    assign O_EXC_RI      = s_q.exc_ri;
    assign O_EXC_DSP_DIS = s_q.exc_dis;
    assign O_DSP_CONTROL = s_q.ctl;
    assign O_ACC_RD_DATA = s_q.acc_rd;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [31:0] cur_low;
    logic [31:0] cur_high;
    logic [5:0]  pos_q;

    assign cur_low  = s_q.acc[sel][31:0];
    assign cur_high = s_q.acc[sel][63:32];
    assign pos_q    = s_q.ctl[5:0];

    a_shift_high_moves: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        go && op == dsam_pkg::OP_SHIFT_IN |=>
        s_q.acc[$past(sel)][63:32] == $past(cur_low)
    ) else $error("shift-in lost old low half");

    a_shift_low_loads: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        go && op == dsam_pkg::OP_SHIFT_IN |=>
        s_q.acc[$past(sel)][31:0] == $past(I_RS_DATA)
    ) else $error("shift-in low half wrong");

    a_pos_adds_step: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        go && op == dsam_pkg::OP_SHIFT_IN && !I_CTL_WE |=>
        pos_q == 6'($past(pos_q) + 6'h20)
    ) else $error("position not advanced by 32");

    a_shift_no_exc: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        I_VALID && op == dsam_pkg::OP_SHIFT_IN && I_DSP_EN |=>
        !O_EXC_RI && !O_EXC_DSP_DIS && O_WB_VALID
    ) else $error("shift-in raised an exception");

    a_low_write_keeps: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        go && op == dsam_pkg::OP_WR_LOW |=>
        s_q.acc[$past(sel)] == {$past(cur_high), $past(I_RS_DATA)}
    ) else $error("low-half write wrong");

    a_mul_wraps: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        go && op == dsam_pkg::OP_PH_MUL |=>
        O_WB_RD_WE && O_WB_RD_DATA == $past(mul_wrap) &&
        O_WB_RD_ADDR == $past(rd_field)
    ) else $error("plain multiply result wrong");

    a_mul_clamps: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        go && op == dsam_pkg::OP_PH_MUL_SAT |=>
        O_WB_RD_DATA == $past(mul_sat)
    ) else $error("saturating multiply result wrong");

    a_ovf_flag_set: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        go && op == dsam_pkg::OP_PH_MUL_SAT && mul_ovf |=>
        O_DSP_CONTROL[21]
    ) else $error("overflow flag not set");

    a_acc_untouched: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        go && is_mul |=> $stable(s_q.acc)
    ) else $error("multiply changed an accumulator");

    a_ri_refuses: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        I_VALID && is_mul && !I_DSP_R2_EN |=>
        O_EXC_RI && !O_WB_VALID && !O_WB_RD_WE
    ) else $error("reserved instruction not raised");

    a_dis_refuses: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        I_VALID && is_mul && I_DSP_R2_EN && !I_DSP_EN && !I_CTL_WE |=>
        O_EXC_DSP_DIS && !O_WB_VALID && $stable(O_DSP_CONTROL[21])
    ) else $error("dsp disabled not raised");

    a_commit_together: assert property (
        @(posedge I_CLK) disable iff (!I_RST_N)
        O_WB_RD_WE |-> O_WB_VALID && !O_EXC_RI && !O_EXC_DSP_DIS
    ) else $error("writeback split from retire");

endmodule

/* File: verif/dsam_core_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// core issue model
// ------------------------------------------------------------
module dsam_core_model (
    input  wire logic        i_clk,
    output logic             o_valid,
    output logic [31:0]      o_instr,
    output logic [31:0]      o_rs,
    output logic [31:0]      o_rt,
    output logic             o_we,
    output logic [31:0]      o_wd
);
    initial begin
        o_valid = 1'b0;
        o_instr = 32'h0;
        o_rs    = 32'h0;
        o_rt    = 32'h0;
        o_we    = 1'b0;
        o_wd    = 32'h0;
    end

    // one slot per edge; idle slots flip the buses so stale data never
    // passes for a live request
    task automatic put(input logic v, input logic [31:0] ins, rs, rt,
                       input logic we, input logic [31:0] wd);
        @(posedge i_clk);
        o_valid <= v;
        o_instr <= v ? ins : ~o_instr;
        o_rs    <= v ? rs : ~o_rs;
        o_rt    <= v ? rt : ~o_rt;
        o_we    <= we;
        o_wd    <= we ? wd : ~o_wd;
    endtask
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
    logic        clk;
    logic        rst_n;
    logic        dsp_en;
    logic        r2_en;
    logic [1:0]  rd_sel;
    logic        valid;
    logic [31:0] instr;
    logic [31:0] rs_d;
    logic [31:0] rt_d;
    logic        ctl_we;
    logic [31:0] ctl_wd;
    logic        wb_valid;
    logic        wb_we;
    logic [4:0]  wb_addr;
    logic [31:0] wb_data;
    logic        exc_ri;
    logic        exc_dis;
    logic [31:0] ctl;
    logic [63:0] acc_rd;
    logic [63:0] acc_exp [4];
    logic [31:0] ctl_exp;
    logic [31:0] last_rd;
    int          n_fail;
    int          num_checks;

    localparam logic [31:0] MUL_A [4] = '{32'h0003_fff0, 32'h7fff_0003,
                                          32'h8000_0100, 32'h8000_ff00};
    localparam logic [31:0] MUL_B [4] = '{32'h0004_0002, 32'h0002_fffe,
                                          32'h0002_0100, 32'h8000_0001};

    dsam_core_model core (.i_clk(clk), .o_valid(valid), .o_instr(instr),
        .o_rs(rs_d), .o_rt(rt_d), .o_we(ctl_we), .o_wd(ctl_wd));

    dsam_datapath #(.NUM_ACC(4)) dut (.I_CLK(clk), .I_RST_N(rst_n),
        .I_VALID(valid), .I_INSTR(instr), .I_RS_DATA(rs_d),
        .I_RT_DATA(rt_d), .I_DSP_EN(dsp_en), .I_DSP_R2_EN(r2_en),
        .I_CTL_WE(ctl_we), .I_CTL_WDATA(ctl_wd), .I_ACC_RD_SEL(rd_sel),
        .O_WB_VALID(wb_valid), .O_WB_RD_WE(wb_we), .O_WB_RD_ADDR(wb_addr),
        .O_WB_RD_DATA(wb_data), .O_EXC_RI(exc_ri), .O_EXC_DSP_DIS(exc_dis),
        .O_DSP_CONTROL(ctl), .O_ACC_RD_DATA(acc_rd));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] enc_acc(input logic [7:0] mn,
                                            input logic [1:0] a);
        return {6'h00, 5'h00, 5'h05, a, mn, 6'h3c};
    endfunction

    function automatic logic [31:0] enc_mul(input logic s,
                                            input logic [4:0] rd);
        return {6'h00, 5'h07, 5'h05, rd, s ? 11'h42d : 11'h02d};
    endfunction

    // top bit flags a lane outside the signed 16-bit range
    function automatic logic [16:0] lane(input logic [15:0] a, b,
                                         input logic s);
        logic signed [31:0] p;
        p = $signed(a) * $signed(b);
        if (p > 32'sh7fff) return {1'b1, s ? 16'h7fff : p[15:0]};
        if (p < 32'shffff_8000) return {1'b1, s ? 16'h8000 : p[15:0]};
        return {1'b0, p[15:0]};
    endfunction

    task automatic check(input logic [63:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic idle;
        core.put(1'b0, 32'h0, 32'h0, 32'h0, 1'b0, 32'h0);
        #1;
    endtask

    task automatic exec(input logic [31:0] ins, rs, rt);
        core.put(1'b1, ins, rs, rt, 1'b0, 32'h0);
        idle();
    endtask

    task automatic ctl_wr(input logic [31:0] d);
        core.put(1'b0, 32'h0, 32'h0, 32'h0, 1'b1, d);
        idle();
        ctl_exp = d;
    endtask

    task automatic chk_acc(input logic [1:0] a);
        @(posedge clk);
        rd_sel <= a;
        @(posedge clk);
        #1;
        check(acc_rd, acc_exp[a]);
    endtask

    task automatic end_of_test;
        if (n_fail == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        @(posedge clk);
        #1;
        check({wb_valid, ctl}, 33'h0);
        for (int a = 0; a < 4; a++) chk_acc(2'(a));
    endtask

    // low write then shift-in back to back on the same accumulator
    task automatic t_shift_in;
        logic [31:0] lo;
        logic [31:0] rs;
        ctl_wr(32'h0);
        for (int a = 0; a < 4; a++) begin
            lo = 32'hc0de_0000 + 32'(a);
            rs = 32'h5a5a_0f00 + 32'(a);
            core.put(1'b1, enc_acc(8'hc1, 2'(a)), lo, ~lo, 1'b0, 32'h0);
            core.put(1'b1, enc_acc(8'h09, 2'(a)), rs, ~rs, 1'b0, 32'h0);
            idle();
            check({wb_valid, exc_ri, exc_dis}, 3'b100);
            acc_exp[a] = {lo, rs};
            ctl_exp[5:0] = ctl_exp[5:0] + 6'h20;
            check(ctl, ctl_exp);
            chk_acc(2'(a));
        end
        core.put(1'b1, enc_acc(8'h09, 2'd3), 32'h0bad_f00d, 32'h0,
                 1'b1, 32'h10);
        idle();
        ctl_exp = 32'h30;
        check(ctl, ctl_exp);
        acc_exp[3] = {acc_exp[3][31:0], 32'h0bad_f00d};
        chk_acc(2'd3);
    endtask

    task automatic t_low_write;
        logic [31:0] lo;
        for (int a = 0; a < 4; a++) begin
            lo = 32'h3c3c_0000 + 32'(a);
            exec(enc_acc(8'hc1, 2'(a)), lo, ~lo);
            check({wb_valid, exc_ri, exc_dis}, 3'b100);
            acc_exp[a][31:0] = lo;
            chk_acc(2'(a));
        end
    endtask

    task automatic t_mul;
        logic [16:0] hi;
        logic [16:0] lo;
        logic        s;
        int          k;
        for (int i = 0; i < 8; i++) begin
            s = i[0];
            k = i / 2;
            hi = lane(MUL_A[k][31:16], MUL_B[k][31:16], s);
            lo = lane(MUL_A[k][15:0], MUL_B[k][15:0], s);
            exec(enc_mul(s, 5'(i + 3)), MUL_A[k], MUL_B[k]);
            check({wb_valid, wb_we, wb_addr}, {2'b11, 5'(i + 3)});
            last_rd = {hi[15:0], lo[15:0]};
            check(wb_data, last_rd);
            if (s && (hi[16] || lo[16])) ctl_exp[21] = 1'b1;
            check(ctl, ctl_exp);
        end
        for (int a = 1; a < 4; a++) chk_acc(2'(a));
    endtask

    // refused words must leave every register as it was
    task automatic t_refuse;
        ctl_wr(32'h0);
        @(posedge clk);
        r2_en <= 1'b0;
        exec(enc_mul(1'b1, 5'h1f), 32'h7fff_7fff, 32'h7fff_7fff);
        check({wb_valid, wb_we, exc_ri, exc_dis}, 4'b0010);
        check({wb_data, ctl}, {last_rd, ctl_exp});
        @(posedge clk);
        r2_en <= 1'b1;
        dsp_en <= 1'b0;
        exec(enc_mul(1'b1, 5'h1f), 32'h7fff_7fff, 32'h7fff_7fff);
        check({wb_valid, wb_we, exc_ri, exc_dis}, 4'b0001);
        exec(enc_acc(8'h09, 2'd2), 32'h1, 32'h0);
        check({wb_valid, exc_ri, exc_dis, ctl}, {3'b001, ctl_exp});
        exec(enc_acc(8'hc1, 2'd1), 32'h2, 32'h0);
        check({wb_valid, exc_ri, exc_dis}, 3'b001);
        exec(enc_acc(8'hc1, 2'd0), 32'h7777_0000, 32'h0);
        check({wb_valid, exc_ri, exc_dis}, 3'b100);
        acc_exp[0][31:0] = 32'h7777_0000;
        @(posedge clk);
        dsp_en <= 1'b1;
        exec(enc_acc(8'hc1, 2'd1) | 32'h0020_0000, 32'h2, 32'h0);
        check({wb_valid, exc_ri, exc_dis}, 3'b000);
        for (int a = 0; a < 4; a++) chk_acc(2'(a));
    endtask

    // ------------------------------------------------------------
    // run
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        end_of_test();
    end

    initial begin
        n_fail = 0;
        num_checks = 0;
        rst_n = 1'b0;
        dsp_en = 1'b1;
        r2_en = 1'b1;
        rd_sel = 2'd0;
        ctl_exp = 32'h0;
        last_rd = 32'h0;
        for (int a = 0; a < 4; a++) acc_exp[a] = 64'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_shift_in();
        t_low_write();
        t_mul();
        t_refuse();
        end_of_test();
    end
endmodule
